// [tcr_edge_sync.sv]
`timescale 1ns/1ps
module tcr_edge_sync
   import tcr_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   input wire logic i_pin,
   output logic o_fall
);
   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         meta_reg <= 1'b1;
         sync_reg <= 1'b1;
         last_reg <= 1'b1;
      end else begin
         meta_reg <= i_pin;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   assign o_fall = last_reg & ~sync_reg;
endmodule

// [tcr_mode_decode.sv]
`timescale 1ns/1ps
module tcr_mode_decode
   import tcr_pkg::*;
(
   input wire logic [7:0] i_ctrl,
   output tcr_mode_t o_mode
);
   always_comb begin
      if (!i_ctrl[TCR_BIT_RUN]) begin
         o_mode = TCR_MODE_OFF;
      end else if (i_ctrl[TCR_BIT_RXCLK] | i_ctrl[TCR_BIT_TXCLK]) begin
         o_mode = TCR_MODE_BAUD;
      end else if (i_ctrl[TCR_BIT_CAP]) begin
         o_mode = TCR_MODE_CAPTURE;
      end else begin
         o_mode = TCR_MODE_RELOAD;
      end
   end
endmodule

// [tcr_pins.sv]
`timescale 1ns/1ps
module tcr_pins (
   input wire logic i_clk_sys,
   input wire logic i_trig_go,
   input wire logic i_cnt_go,
   output logic o_trigger_pin,
   output logic o_count_input_pin,
   output logic o_timer1_ovf
);
   logic [2:0] low_reg = 3'h0;
   logic [2:0] t1_reg = 3'h0;
   logic cnt_reg = 1'b1;
   // The trigger line idles high on its pull-up and is pulled low for three cycles.
   assign o_trigger_pin = (low_reg == 3'h0);
   assign o_count_input_pin = cnt_reg;
   assign o_timer1_ovf = (t1_reg == 3'h7);
   always @(posedge i_clk_sys) begin
      t1_reg <= t1_reg + 3'h1;
      if (i_trig_go) low_reg <= 3'h3;
      else if (low_reg != 3'h0) low_reg <= low_reg - 3'h1;
      if (i_cnt_go) cnt_reg <= ~cnt_reg;
   end
endmodule

// [tcr_pkg.sv]
// Notes on behaviour
// - Overflow flag set on rollover, not in baud mode
// - External flag set on accepted trigger edge
// - Receive clock select routes our overflow
// - Transmit clock select routes our overflow
// - Trigger edges ignored unless enabled, running and not baud
// - Count only while run bit set
// - Counter select picks pin edges or core clock
// - Baud mode forces auto-reload, ignores capture select
// - Mode decoded from control bits
// - Auto-reload: rollover sets flag, loads reload value
// - Auto-reload: trigger edge also reloads, sets flag
// - Capture mode: free run, overflow sets flag
// - Capture mode: trigger edge copies count, sets flag
// - Baud mode: no overflow interrupt, trigger edges ignored so no external flag
// - Count and reload as byte register pairs
// - Control resets zero, bits individually writable
package tcr_pkg;
   localparam logic [7:0] TCR_ADDR_CTRL = 8'hC8;
   localparam logic [7:0] TCR_ADDR_RLD_LO = 8'hCA;
   localparam logic [7:0] TCR_ADDR_RLD_HI = 8'hCB;
   localparam logic [7:0] TCR_ADDR_CNT_LO = 8'hCC;
   localparam logic [7:0] TCR_ADDR_CNT_HI = 8'hCD;
   localparam logic [7:0] TCR_CTRL_RESET = 8'h00;
   localparam logic [15:0] TCR_WORD_RESET = 16'h0000;
   localparam int TCR_BIT_OVF = 7;
   localparam int TCR_BIT_EXF = 6;
   localparam int TCR_BIT_RXCLK = 5;
   localparam int TCR_BIT_TXCLK = 4;
   localparam int TCR_BIT_EXEN = 3;
   localparam int TCR_BIT_RUN = 2;
   localparam int TCR_BIT_CNT = 1;
   localparam int TCR_BIT_CAP = 0;
   typedef enum logic [3:0] {
      TCR_MODE_OFF = 4'h1,
      TCR_MODE_RELOAD = 4'h2,
      TCR_MODE_CAPTURE = 4'h4,
      TCR_MODE_BAUD = 4'h8
   } tcr_mode_t;
endpackage

// [tcr_props.sv]
`timescale 1ns/1ps
module tcr_props
   import tcr_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   input wire logic [7:0] i_sfr_addr,
   input wire logic i_sfr_wr,
   input wire logic i_bit_wr,
   input wire logic [7:0] o_sfr_rdata,
   input wire logic o_sfr_hit,
   input wire logic i_timer1_ovf,
   input wire logic o_rx_baud_tick,
   input wire logic o_tx_baud_tick,
   input wire logic o_ovf_pulse,
   input wire logic o_irq
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);
   logic c8;
   logic sw;
   assign c8 = (i_sfr_addr == TCR_ADDR_CTRL);
   assign sw = i_sfr_wr | i_bit_wr;
   property p_hit; o_sfr_hit == (c8 || i_sfr_addr inside {[8'hCA:8'hCD]}); endproperty
   a_hit: assert property (p_hit) else $error("map");
   property p_unmap; !o_sfr_hit |-> o_sfr_rdata == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped");
   property p_irq; c8 |-> o_irq == (|o_sfr_rdata[7:6]); endproperty
   a_irq: assert property (p_irq) else $error("irq");
   property p_hold; o_irq && !sw |=> o_irq; endproperty
   a_hold: assert property (p_hold) else $error("flag lost");
   property p_rx; c8 && !o_sfr_rdata[5] |-> o_rx_baud_tick == i_timer1_ovf; endproperty
   a_rx: assert property (p_rx) else $error("rx tick");
   property p_tx; c8 && !o_sfr_rdata[4] |-> o_tx_baud_tick == i_timer1_ovf; endproperty
   a_tx: assert property (p_tx) else $error("tx tick");
   property p_rx_sel; c8 && o_sfr_rdata[5] |-> o_rx_baud_tick == o_ovf_pulse; endproperty
   a_rx_sel: assert property (p_rx_sel) else $error("rx own tick");
   property p_tx_sel; c8 && o_sfr_rdata[4] |-> o_tx_baud_tick == o_ovf_pulse; endproperty
   a_tx_sel: assert property (p_tx_sel) else $error("tx own tick");
   property p_baud; c8 && |o_sfr_rdata[5:4] && !o_sfr_rdata[7] && !sw |=> !c8 || !o_sfr_rdata[7];
   endproperty
   a_baud: assert property (p_baud) else $error("baud flag");
   property p_ovf; o_ovf_pulse && c8 && o_sfr_rdata[5:4] == 2'h0 |-> o_sfr_rdata[7]; endproperty
   a_ovf: assert property (p_ovf) else $error("ovf flag");
endmodule
bind tcr_timer_two tcr_props u_props(.*);

// [tcr_timer_two.sv]
`timescale 1ns/1ps
module tcr_timer_two
   import tcr_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   input wire logic [7:0] i_sfr_addr,
   input wire logic i_sfr_wr,
   input wire logic [7:0] i_sfr_wdata,
   input wire logic i_bit_wr,
   input wire logic [2:0] i_bit_sel,
   input wire logic i_bit_val,
   output logic [7:0] o_sfr_rdata,
   output logic o_sfr_hit,
   input wire logic i_trigger_pin,
   input wire logic i_count_input_pin,
   input wire logic i_timer1_ovf,
   output logic o_rx_baud_tick,
   output logic o_tx_baud_tick,
   output logic o_ovf_pulse,
   output logic o_irq
);
   // ****************************************************************
   // Registers and decode
   // ****************************************************************
   logic [7:0] ctrl_reg;
   logic [15:0] count_reg;
   logic [15:0] reload_reg;
   logic [7:0] ctrl_wval;
   logic ctrl_wr;
   logic trig_fall;
   logic cnt_fall;
   logic tick;
   logic rollover;
   logic trig_ok;
   logic ovf_reg;
   tcr_mode_t mode;

   tcr_edge_sync u_trig_sync (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .i_pin(i_trigger_pin),
      .o_fall(trig_fall)
   );

   tcr_edge_sync u_cnt_sync (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .i_pin(i_count_input_pin),
      .o_fall(cnt_fall)
   );

   tcr_mode_decode u_mode (
      .i_ctrl(ctrl_reg),
      .o_mode(mode)
   );

   // Bit access changes one control bit; byte access replaces all.
   always_comb begin
      ctrl_wval = ctrl_reg;
      ctrl_wr = 1'b0;
      if (i_sfr_addr == TCR_ADDR_CTRL) begin
         if (i_sfr_wr) begin
            ctrl_wval = i_sfr_wdata;
            ctrl_wr = 1'b1;
         end else if (i_bit_wr) begin
            ctrl_wval[i_bit_sel] = i_bit_val;
            ctrl_wr = 1'b1;
         end
      end
   end

   // ****************************************************************
   // Counting
   // ****************************************************************
   assign tick = (mode != TCR_MODE_OFF) &
                 (ctrl_reg[TCR_BIT_CNT] ? cnt_fall : 1'b1);
   assign rollover = tick & (count_reg == 16'hFFFF);
   assign trig_ok = trig_fall & ctrl_reg[TCR_BIT_EXEN] &
                    (mode != TCR_MODE_BAUD) & (mode != TCR_MODE_OFF);

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         count_reg <= TCR_WORD_RESET;
      end else if (i_sfr_wr && i_sfr_addr == TCR_ADDR_CNT_LO) begin
         count_reg[7:0] <= i_sfr_wdata;
      end else if (i_sfr_wr && i_sfr_addr == TCR_ADDR_CNT_HI) begin
         count_reg[15:8] <= i_sfr_wdata;
      end else if (rollover && mode != TCR_MODE_CAPTURE) begin
         count_reg <= reload_reg;
      end else if (trig_ok && mode == TCR_MODE_RELOAD) begin
         count_reg <= reload_reg;
      end else if (tick) begin
         count_reg <= count_reg + 16'h0001;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         reload_reg <= TCR_WORD_RESET;
      end else if (trig_ok && mode == TCR_MODE_CAPTURE) begin
         reload_reg <= count_reg;
      end else if (i_sfr_wr && i_sfr_addr == TCR_ADDR_RLD_LO) begin
         reload_reg[7:0] <= i_sfr_wdata;
      end else if (i_sfr_wr && i_sfr_addr == TCR_ADDR_RLD_HI) begin
         reload_reg[15:8] <= i_sfr_wdata;
      end
   end

   // ****************************************************************
   // Control register and flags
   // ****************************************************************
   // Hardware setting a flag wins over a software clear in the same cycle.
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         ctrl_reg <= TCR_CTRL_RESET;
      end else begin
         if (ctrl_wr) begin
            ctrl_reg <= ctrl_wval;
         end
         if (rollover && mode != TCR_MODE_BAUD) begin
            ctrl_reg[TCR_BIT_OVF] <= 1'b1;
         end
         if (trig_ok) begin
            ctrl_reg[TCR_BIT_EXF] <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         ovf_reg <= 1'b0;
      end else begin
         ovf_reg <= rollover;
      end
   end

   // ****************************************************************
   // Read path and outputs
   // ****************************************************************
   always_comb begin
      o_sfr_hit = 1'b1;
      case (i_sfr_addr)
         TCR_ADDR_CTRL: o_sfr_rdata = ctrl_reg;
         TCR_ADDR_RLD_LO: o_sfr_rdata = reload_reg[7:0];
         TCR_ADDR_RLD_HI: o_sfr_rdata = reload_reg[15:8];
         TCR_ADDR_CNT_LO: o_sfr_rdata = count_reg[7:0];
         TCR_ADDR_CNT_HI: o_sfr_rdata = count_reg[15:8];
         default: begin
            o_sfr_rdata = 8'h00;
            o_sfr_hit = 1'b0;
         end
      endcase
   end

   assign o_ovf_pulse = ovf_reg;
   assign o_rx_baud_tick = ctrl_reg[TCR_BIT_RXCLK] ? ovf_reg : i_timer1_ovf;
   assign o_tx_baud_tick = ctrl_reg[TCR_BIT_TXCLK] ? ovf_reg : i_timer1_ovf;
   assign o_irq = ctrl_reg[TCR_BIT_OVF] | ctrl_reg[TCR_BIT_EXF];
endmodule

// [testbench.sv]
`timescale 1ns/1ps
module testbench import tcr_pkg::*;;
   logic i_clk_sys = 0, i_nrst = 0, i_sfr_wr = 0, i_bit_wr = 0, i_bit_val = 0;
   logic rd_en = 0, trig_go = 0, cnt_go = 0, o_sfr_hit, o_irq, o_ovf_pulse;
   logic i_trigger_pin, i_count_input_pin, i_timer1_ovf, o_rx_baud_tick, o_tx_baud_tick;
   logic [7:0] i_sfr_addr = 0, i_sfr_wdata = 0, o_sfr_rdata, r, e;
   logic [2:0] i_bit_sel = 0;
   logic [7:0] exp_q[$];
   int error_cnt = 0, samples_checked = 0, cyc = 0, ovf_seen = 0;
   always #5 i_clk_sys = ~i_clk_sys;
   tcr_timer_two u_dut(.*);
   tcr_pins u_pins(.i_clk_sys, .i_trig_go(trig_go), .i_cnt_go(cnt_go),
      .o_trigger_pin(i_trigger_pin), .o_count_input_pin(i_count_input_pin),
      .o_timer1_ovf(i_timer1_ovf));
   task wrap_up;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Kind 0 writes a byte, 1 writes one control bit, 2 reads and expects d.
   task op(input int k, input logic [7:0] a, input logic [7:0] d);
      i_sfr_addr = a;
      i_sfr_wdata = d;
      i_bit_sel = d[2:0];
      i_bit_val = d[3];
      i_sfr_wr = (k == 0);
      i_bit_wr = (k == 1);
      rd_en = (k == 2);
      if (k == 2) exp_q.push_back(d);
      @(negedge i_clk_sys);
      {i_sfr_wr, i_bit_wr, rd_en} = 3'h0;
      @(negedge i_clk_sys);
   endtask
   task trig;
      trig_go = 1;
      @(negedge i_clk_sys);
      trig_go = 0;
      repeat (6) @(negedge i_clk_sys);
   endtask
   always @(posedge i_clk_sys) begin
      if (rd_en) begin
         e = exp_q.pop_front();
         samples_checked++;
         if (o_sfr_rdata !== e) begin
            $display("[FAIL] reg %h expected %h seen %h", i_sfr_addr, e, o_sfr_rdata);
            error_cnt++;
         end
         if (i_sfr_addr == TCR_ADDR_CTRL && o_irq !== (|e[7:6])) begin
            $display("[FAIL] irq expected %b seen %b", |e[7:6], o_irq);
            error_cnt++;
         end
      end
   end
   always @(posedge i_clk_sys) begin
      cyc++;
      if (o_ovf_pulse === 1'b1) ovf_seen++;
      if (cyc == 2000) begin
         error_cnt++;
         wrap_up;
      end
   end
   initial begin
      r = 8'($urandom(42));
      repeat (4) @(negedge i_clk_sys);
      i_nrst = 1;
      op(2, 8'hC8, 8'h00);
      op(2, 8'hCC, 8'h00);
      op(2, 8'hC9, 8'h00);
      op(0, 8'hCC, 8'hFE);
      op(0, 8'hCD, 8'hFF);
      op(0, 8'hCA, 8'h34);
      op(0, 8'hCB, 8'h12);
      op(0, 8'hC8, 8'h04);
      repeat (4) @(negedge i_clk_sys);
      op(2, 8'hC8, 8'h84);
      op(2, 8'hCD, 8'h12);
      op(1, 8'hC8, 8'h07);
      op(2, 8'hC8, 8'h04);
      op(0, 8'hC8, 8'h0F);
      op(0, 8'hCC, 8'hCD);
      op(0, 8'hCD, 8'hAB);
      trig;
      op(2, 8'hCA, 8'hCD);
      op(2, 8'hCB, 8'hAB);
      op(2, 8'hC8, 8'h4F);
      cnt_go = 1;
      repeat (6) @(negedge i_clk_sys);
      cnt_go = 0;
      repeat (4) @(negedge i_clk_sys);
      op(2, 8'hCC, 8'hD0);
      op(0, 8'hCA, 8'h11);
      op(0, 8'hCB, 8'h22);
      op(0, 8'hC8, 8'h0E);
      trig;
      op(2, 8'hCC, 8'h11);
      op(2, 8'hC8, 8'h4E);
      op(0, 8'hCC, 8'hF0);
      op(0, 8'hCD, 8'hFF);
      op(0, 8'hC8, 8'h3D);
      trig;
      repeat (20) @(negedge i_clk_sys);
      op(2, 8'hC8, 8'h3D);
      op(2, 8'hCD, 8'h22);
      op(0, 8'hC8, 8'h00);
      r = 8'($urandom);
      op(0, 8'hCC, r);
      repeat (5) @(negedge i_clk_sys);
      op(2, 8'hCC, r);
      samples_checked++;
      if (ovf_seen != 2) begin
         $display("[FAIL] ovf_pulse count expected 2 seen %0d", ovf_seen);
         error_cnt++;
      end
      wrap_up;
   end
endmodule
